/* File: hdl/fsag_pkg.sv */
// Package for the flash security access guard: map, codes and carriers
package fsag_pkg;

  // ****************************************************************
  // Register map of the software register port
  // ****************************************************************
  localparam logic [2:0] FSAG_OFS_STORE_CONTROL = 3'h0; // Permit bits
  localparam logic [2:0] FSAG_OFS_ACCESS_LIMIT  = 3'h1; // Read limit byte
  localparam logic [2:0] FSAG_OFS_READ_LOCK     = 3'h2; // Read lock copy
  localparam logic [2:0] FSAG_OFS_WRITE_LOCK    = 3'h3; // Write lock copy
  localparam logic [2:0] FSAG_OFS_STATUS        = 3'h4; // Refusal flags

  // Field positions
  localparam int FSAG_BIT_WRITE_PERMIT = 0; // Store write permit
  localparam int FSAG_BIT_ERASE_PERMIT = 1; // Store erase permit
  localparam int FSAG_BIT_CPU_REFUSED  = 0; // Core access refused
  localparam int FSAG_BIT_JTAG_REFUSED = 1; // Debug access refused

  // Values after reset
  localparam logic [7:0] FSAG_RST_STORE_CONTROL = 8'h00;
  localparam logic [7:0] FSAG_RST_ACCESS_LIMIT  = 8'h00; // Full read access
  localparam logic [7:0] FSAG_RST_LOCK          = 8'hff; // Until loaded

  // ****************************************************************
  // Flash address map
  // ****************************************************************
  localparam logic [15:0] FSAG_ADDR_READ_LOCK  = 16'h1dff;
  localparam logic [15:0] FSAG_ADDR_WRITE_LOCK = 16'h1dfe;
  localparam logic [15:0] FSAG_LOCK_PAGE_LO    = 16'h1c00;
  localparam logic [15:0] FSAG_LOCK_PAGE_HI    = 16'h1dff;
  localparam logic [15:0] FSAG_SCRATCH_LO      = 16'h2000;
  localparam logic [15:0] FSAG_SCRATCH_HI      = 16'h207f;
  localparam int          FSAG_BLOCK_SHIFT     = 10; // 1 kB lock blocks
  localparam logic [7:0]  FSAG_BLOCKED_DATA    = 8'h00;

  // ****************************************************************
  // Codes and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    FSAG_CPU_FETCH,       // Instruction fetch
    FSAG_CPU_CODE_READ,   // code_read_instruction
    FSAG_CPU_MOVE_WRITE   // external_move_instruction write
  } fsag_cpu_op_type;

  typedef enum logic [1:0] {
    FSAG_JTAG_READ,
    FSAG_JTAG_WRITE,
    FSAG_JTAG_ERASE
  } fsag_jtag_op_type;

  typedef enum logic [1:0] {
    FSAG_FL_READ,
    FSAG_FL_WRITE,
    FSAG_FL_ERASE_PAGE,
    FSAG_FL_ERASE_ALL
  } fsag_flash_op_type;

  typedef struct packed {
    logic            valid;
    fsag_cpu_op_type op;
    logic [15:0]     pc;    // Address of executing instruction
    logic [15:0]     addr;  // Target address
    logic [7:0]      wdata;
  } fsag_cpu_req_type;

  typedef struct packed {
    logic             valid;
    fsag_jtag_op_type op;
    logic [15:0]      addr;
    logic [7:0]       wdata;
  } fsag_jtag_req_type;

  typedef struct packed {
    logic       valid;   // One-cycle answer
    logic       refused; // Access was blocked
    logic [7:0] rdata;
  } fsag_rsp_type;

  typedef struct packed {
    logic              valid; // One-cycle command
    fsag_flash_op_type op;
    logic [15:0]       addr;
    logic [7:0]        wdata;
  } fsag_flash_cmd_type;

endpackage

/* File: hdl/fsag_guard.sv */
// Flash security access guard between core, debug port and flash array
`timescale 1ns/1ps
`default_nettype none

module fsag_guard
  import fsag_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  // Software register port
  input  wire logic [2:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [7:0]         reg_rdata,
  // Core requests and answers
  input  wire fsag_cpu_req_type   cpu_req,
  output var  logic               cpu_ready,
  output var  fsag_rsp_type       cpu_rsp,
  // Debug port requests and answers
  input  wire fsag_jtag_req_type  jtag_req,
  output var  logic               jtag_ready,
  output var  fsag_rsp_type       jtag_rsp,
  // Flash array
  output var  fsag_flash_cmd_type flash_cmd,
  input  wire logic               flash_busy,
  input  wire logic               flash_rvalid,
  input  wire logic [7:0]         flash_rdata
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Address lies in the lower partition
  function automatic logic below_limit(input logic [15:0] a,
                                       input logic [15:0] lim);
    below_limit = (a < lim);
  endfunction

  // Lock bit of the 1 kB block holding the address; beyond 8 kB open
  function automatic logic lock_open(input logic [7:0]  lock,
                                     input logic [15:0] a);
    logic [5:0] blk;
    blk = a[15:FSAG_BLOCK_SHIFT];
    if (blk > 6'h07) begin
      lock_open = 1'b1;
    end else begin
      lock_open = lock[blk[2:0]];
    end
  endfunction

  // Address inside the page that holds the lock bytes
  function automatic logic in_lock_page(input logic [15:0] a);
    in_lock_page = (a >= FSAG_LOCK_PAGE_LO) && (a <= FSAG_LOCK_PAGE_HI);
  endfunction

  // Address is one of the two lock bytes
  function automatic logic is_lock_byte(input logic [15:0] a);
    is_lock_byte = (a == FSAG_ADDR_READ_LOCK) ||
                   (a == FSAG_ADDR_WRITE_LOCK);
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [2:0] {
    FSAG_ST_BOOT_RD_RLOCK,  // Ask for read lock byte
    FSAG_ST_BOOT_WT_RLOCK,  // Wait for it
    FSAG_ST_BOOT_RD_WLOCK,  // Ask for write lock byte
    FSAG_ST_BOOT_WT_WLOCK,  // Wait for it
    FSAG_ST_IDLE,           // Ready for requests
    FSAG_ST_WAIT_READ       // Flash read in flight
  } fsag_state_type;

  fsag_state_type     state_q;        // Sequencer state
  fsag_state_type     state_d;        // Next state
  logic               owner_jtag_q;   // Pending read belongs to debug
  logic [7:0]         control_q;      // Store control register
  logic [7:0]         limit_byte_q;   // Flash access limit register
  logic [15:0]        read_limit_q;   // Software read limit
  logic [7:0]         rlock_q;        // Read lock copy
  logic [7:0]         wlock_q;        // Write lock copy
  logic [1:0]         refused_q;      // Sticky refusal flags
  logic               ready_q;        // Shared request ready
  logic [7:0]         rdata_q;        // Register read data
  fsag_rsp_type       cpu_rsp_q;      // Core answer
  fsag_rsp_type       jtag_rsp_q;     // Debug answer
  fsag_flash_cmd_type cmd_q;          // Flash command
  fsag_flash_cmd_type cmd_d;          // Next flash command
  logic               take_jtag;      // Debug request taken now
  logic               take_cpu;       // Core request taken now
  logic               cpu_block;      // Partition check fails
  logic               cpu_refuse;     // Core request refused
  logic               jtag_refuse;    // Debug request refused
  logic               jtag_erase_all; // Debug erase at a lock byte: full erase
  logic               lock_page_gone; // Lock page is being erased

  // Debug wins when both ask in one cycle; core holds its request
  assign take_jtag = ready_q && jtag_req.valid;
  assign take_cpu  = ready_q && cpu_req.valid && !jtag_req.valid;

  // ****************************************************************
  // Access checks
  // ****************************************************************

  // Partition check on instruction address and target address
  always_comb begin
    cpu_block = !below_limit(cpu_req.pc, read_limit_q) &&
                below_limit(cpu_req.addr, read_limit_q);
  end

  // Core refusal by operation
  always_comb begin
    case (cpu_req.op)
      FSAG_CPU_FETCH: begin
        cpu_refuse = 1'b0;
      end
      FSAG_CPU_CODE_READ: begin
        cpu_refuse = cpu_block;
      end
      FSAG_CPU_MOVE_WRITE: begin
        // Permits first, then partition, then lock sector erase
        cpu_refuse = !control_q[FSAG_BIT_WRITE_PERMIT] ||
                     cpu_block ||
                     (control_q[FSAG_BIT_ERASE_PERMIT] &&
                      in_lock_page(cpu_req.addr));
      end
      default: begin
        cpu_refuse = 1'b1;
      end
    endcase
  end

  // Debug refusal by operation and block lock bit
  always_comb begin
    jtag_erase_all = 1'b0;
    case (jtag_req.op)
      FSAG_JTAG_READ: begin
        jtag_refuse = !is_lock_byte(jtag_req.addr) &&
                      !lock_open(rlock_q, jtag_req.addr);
      end
      FSAG_JTAG_WRITE: begin
        jtag_refuse = !is_lock_byte(jtag_req.addr) &&
                      !lock_open(wlock_q, jtag_req.addr);
      end
      FSAG_JTAG_ERASE: begin
        jtag_erase_all = is_lock_byte(jtag_req.addr);
        jtag_refuse    = !jtag_erase_all &&
                         !lock_open(wlock_q, jtag_req.addr);
      end
      default: begin
        jtag_refuse = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Flash command selection
  // ****************************************************************

  // Builds the next flash command for boot and for taken requests
  always_comb begin
    cmd_d       = '0;
    cmd_d.op    = FSAG_FL_READ;
    cmd_d.addr  = 16'h0000;
    cmd_d.wdata = 8'h00;
    if (state_q == FSAG_ST_BOOT_RD_RLOCK) begin
      cmd_d.valid = 1'b1;
      cmd_d.addr  = FSAG_ADDR_READ_LOCK;
    end else if (state_q == FSAG_ST_BOOT_RD_WLOCK) begin
      cmd_d.valid = 1'b1;
      cmd_d.addr  = FSAG_ADDR_WRITE_LOCK;
    end else if (take_jtag && !jtag_refuse) begin
      cmd_d.valid = 1'b1;
      cmd_d.addr  = jtag_req.addr;
      cmd_d.wdata = jtag_req.wdata;
      case (jtag_req.op)
        FSAG_JTAG_READ: begin
          cmd_d.op = FSAG_FL_READ;
        end
        FSAG_JTAG_WRITE: begin
          cmd_d.op = FSAG_FL_WRITE;
        end
        FSAG_JTAG_ERASE: begin
          // Lock byte erases everything; other page bytes their page
          cmd_d.op = jtag_erase_all ? FSAG_FL_ERASE_ALL
                                    : FSAG_FL_ERASE_PAGE;
        end
        default: begin
          cmd_d.valid = 1'b0;
        end
      endcase
    end else if (take_cpu && !cpu_refuse) begin
      cmd_d.valid = 1'b1;
      cmd_d.addr  = cpu_req.addr;
      cmd_d.wdata = cpu_req.wdata;
      case (cpu_req.op)
        FSAG_CPU_FETCH, FSAG_CPU_CODE_READ: begin
          cmd_d.op = FSAG_FL_READ;
        end
        FSAG_CPU_MOVE_WRITE: begin
          // Erase permit turns the write into a page erase; the
          // array sizes the page, 128 bytes in the scratch sector
          cmd_d.op = control_q[FSAG_BIT_ERASE_PERMIT]
                     ? FSAG_FL_ERASE_PAGE
                     : FSAG_FL_WRITE;
        end
        default: begin
          cmd_d.valid = 1'b0;
        end
      endcase
    end
  end

  // Lock page wiped by a page erase or a full erase
  assign lock_page_gone = cmd_d.valid &&
                          ((cmd_d.op == FSAG_FL_ERASE_ALL) ||
                           ((cmd_d.op == FSAG_FL_ERASE_PAGE) &&
                            in_lock_page(cmd_d.addr)));

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Next state: boot reads both lock bytes, then serves requests
  always_comb begin
    case (state_q)
      FSAG_ST_BOOT_RD_RLOCK: begin
        state_d = FSAG_ST_BOOT_WT_RLOCK;
      end
      FSAG_ST_BOOT_WT_RLOCK: begin
        state_d = flash_rvalid ? FSAG_ST_BOOT_RD_WLOCK
                               : FSAG_ST_BOOT_WT_RLOCK;
      end
      FSAG_ST_BOOT_RD_WLOCK: begin
        state_d = FSAG_ST_BOOT_WT_WLOCK;
      end
      FSAG_ST_BOOT_WT_WLOCK: begin
        state_d = flash_rvalid ? FSAG_ST_IDLE : FSAG_ST_BOOT_WT_WLOCK;
      end
      FSAG_ST_IDLE: begin
        if (cmd_d.valid && cmd_d.op == FSAG_FL_READ) begin
          state_d = FSAG_ST_WAIT_READ;
        end else begin
          state_d = FSAG_ST_IDLE;
        end
      end
      FSAG_ST_WAIT_READ: begin
        state_d = flash_rvalid ? FSAG_ST_IDLE : FSAG_ST_WAIT_READ;
      end
      default: begin
        state_d = FSAG_ST_BOOT_RD_RLOCK;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= FSAG_ST_BOOT_RD_RLOCK;
    end else begin
      state_q <= state_d;
    end
  end

  // Owner of a pending flash read
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      owner_jtag_q <= 1'b0;
    end else if (take_jtag || take_cpu) begin
      owner_jtag_q <= take_jtag;
    end
  end

  // Ready drops for a cycle after each take and while flash works
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ready_q <= 1'b0;
    end else begin
      // Low in the answer cycle of a read: a request still held there
      // must not be taken a second time
      ready_q <= (state_d == FSAG_ST_IDLE) &&
                 (state_q != FSAG_ST_WAIT_READ) && !take_jtag &&
                 !take_cpu && !flash_busy;
    end
  end

  // Flash command register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmd_q <= '0;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // ****************************************************************
  // Answers
  // ****************************************************************

  // Core answer: refused reads give zero, writes answer at once
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cpu_rsp_q <= '0;
    end else if (take_cpu && (cpu_refuse ||
                 cpu_req.op == FSAG_CPU_MOVE_WRITE)) begin
      cpu_rsp_q.valid   <= 1'b1;
      cpu_rsp_q.refused <= cpu_refuse;
      cpu_rsp_q.rdata   <= FSAG_BLOCKED_DATA;
    end else if (state_q == FSAG_ST_WAIT_READ && flash_rvalid &&
                 !owner_jtag_q) begin
      cpu_rsp_q.valid   <= 1'b1;
      cpu_rsp_q.refused <= 1'b0;
      cpu_rsp_q.rdata   <= flash_rdata;
    end else begin
      cpu_rsp_q <= '0;
    end
  end

  // Debug answer: refused reads give zero
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      jtag_rsp_q <= '0;
    end else if (take_jtag && (jtag_refuse ||
                 jtag_req.op != FSAG_JTAG_READ)) begin
      jtag_rsp_q.valid   <= 1'b1;
      jtag_rsp_q.refused <= jtag_refuse;
      jtag_rsp_q.rdata   <= FSAG_BLOCKED_DATA;
    end else if (state_q == FSAG_ST_WAIT_READ && flash_rvalid &&
                 owner_jtag_q) begin
      jtag_rsp_q.valid   <= 1'b1;
      jtag_rsp_q.refused <= 1'b0;
      jtag_rsp_q.rdata   <= flash_rdata;
    end else begin
      jtag_rsp_q <= '0;
    end
  end

  // ****************************************************************
  // Lock byte copies
  // ****************************************************************

  // Read lock copy: loaded at boot, writes only clear, erase sets
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rlock_q <= FSAG_RST_LOCK;
    end else if (state_q == FSAG_ST_BOOT_WT_RLOCK && flash_rvalid) begin
      rlock_q <= flash_rdata;
    end else if (lock_page_gone) begin
      rlock_q <= 8'hff;
    end else if (cmd_d.valid && cmd_d.op == FSAG_FL_WRITE &&
                 cmd_d.addr == FSAG_ADDR_READ_LOCK) begin
      rlock_q <= rlock_q & cmd_d.wdata;
    end
  end

  // Write lock copy: same handling as the read lock copy
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wlock_q <= FSAG_RST_LOCK;
    end else if (state_q == FSAG_ST_BOOT_WT_WLOCK && flash_rvalid) begin
      wlock_q <= flash_rdata;
    end else if (lock_page_gone) begin
      wlock_q <= 8'hff;
    end else if (cmd_d.valid && cmd_d.op == FSAG_FL_WRITE &&
                 cmd_d.addr == FSAG_ADDR_WRITE_LOCK) begin
      wlock_q <= wlock_q & cmd_d.wdata;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************

  // Store control: only the two permit bits exist
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      control_q <= FSAG_RST_STORE_CONTROL;
    end else if (reg_wr && reg_addr == FSAG_OFS_STORE_CONTROL) begin
      control_q <= {6'h00, reg_wdata[FSAG_BIT_ERASE_PERMIT],
                    reg_wdata[FSAG_BIT_WRITE_PERMIT]};
    end
  end

  // Flash access limit byte
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      limit_byte_q <= FSAG_RST_ACCESS_LIMIT;
    end else if (reg_wr && reg_addr == FSAG_OFS_ACCESS_LIMIT) begin
      limit_byte_q <= reg_wdata;
    end
  end

  // Read limit follows the limit byte on a 256-byte boundary
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      read_limit_q <= {FSAG_RST_ACCESS_LIMIT, 8'h00};
    end else begin
      read_limit_q <= {limit_byte_q, 8'h00};
    end
  end

  // Sticky refusal flags, write one to clear, new refusal wins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      refused_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if ((i == FSAG_BIT_CPU_REFUSED && take_cpu && cpu_refuse) ||
            (i == FSAG_BIT_JTAG_REFUSED && take_jtag && jtag_refuse))
        begin
          refused_q[i] <= 1'b1;
        end else if (reg_wr && reg_addr == FSAG_OFS_STATUS &&
                     reg_wdata[i]) begin
          refused_q[i] <= 1'b0;
        end
      end
    end
  end

  // Read data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!reset_n || !reg_rd) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        FSAG_OFS_STORE_CONTROL: rdata_q <= control_q;
        FSAG_OFS_ACCESS_LIMIT:  rdata_q <= limit_byte_q;
        FSAG_OFS_READ_LOCK:     rdata_q <= rlock_q;
        FSAG_OFS_WRITE_LOCK:    rdata_q <= wlock_q;
        FSAG_OFS_STATUS:        rdata_q <= {6'h00, refused_q};
        default:                rdata_q <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata  = rdata_q;
  assign cpu_ready  = ready_q;
  assign jtag_ready = ready_q;
  assign cpu_rsp    = cpu_rsp_q;
  assign jtag_rsp   = jtag_rsp_q;
  assign flash_cmd  = cmd_q;

endmodule

`default_nettype wire

/* File: test/fsag_guard_assertions.sv */
// Port checker of the flash security access guard
`timescale 1ns/1ps
`default_nettype none
module fsag_guard_assertions import fsag_pkg::*; (
  // Watched ports
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic [2:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire fsag_cpu_req_type   cpu_req,
  input wire logic               cpu_ready,
  input wire fsag_rsp_type       cpu_rsp,
  input wire fsag_jtag_req_type  jtag_req,
  input wire logic               jtag_ready,
  input wire fsag_flash_cmd_type flash_cmd
);
  logic [1:0] ctl_q; // Shadow permits
  logic [7:0] lim_q; // Shadow limit byte
  logic       tc;    // Core request taken
  logic       mw;    // Core move write taken
  logic       up;    // Upper code aims below limit
  logic [15:0] srl_q; // Read limit, one cycle behind the byte
  // Read limit follows the limit byte one cycle late
  always_ff @(posedge core_clk) srl_q <= {lim_q, 8'h00};
  // Shadows follow register writes
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctl_q <= 2'h0;
      lim_q <= 8'h00;
    end else if (reg_wr && reg_addr == FSAG_OFS_STORE_CONTROL) begin
      ctl_q <= reg_wdata[1:0];
    end else if (reg_wr && reg_addr == FSAG_OFS_ACCESS_LIMIT) begin
      lim_q <= reg_wdata;
    end
  end
  assign tc = cpu_ready && cpu_req.valid && !jtag_req.valid;
  assign mw = tc && cpu_req.op == FSAG_CPU_MOVE_WRITE;
  assign up = cpu_req.pc >= srl_q && cpu_req.addr < srl_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Refused answer next cycle, no flash command
  sequence s_ref;
    ##1 cpu_rsp.valid && cpu_rsp.refused && !flash_cmd.valid;
  endsequence
  a_no_permit: assert property (
    mw && !ctl_q[0] |-> s_ref) else $error("write without permit");
  a_cross_read: assert property (
    tc && cpu_req.op == FSAG_CPU_CODE_READ && up |-> s_ref)
    else $error("cross read not refused");
  a_zero_data: assert property (
    cpu_rsp.valid && cpu_rsp.refused |-> cpu_rsp.rdata == 8'h00)
    else $error("refused data not zero");
  a_fetch_free: assert property (
    tc && cpu_req.op == FSAG_CPU_FETCH |=> flash_cmd.valid
    && flash_cmd.op == FSAG_FL_READ) else $error("fetch blocked");
  a_lock_sector: assert property (
    mw && ctl_q[1] && cpu_req.addr inside {[16'h1c00:16'h1dff]} |-> s_ref)
    else $error("lock sector erased");
  a_erase_page: assert property (
    mw && ctl_q == 2'h3 && !up && !(cpu_req.addr inside {[16'h1c00:16'h1dff]})
    |=> flash_cmd.valid && flash_cmd.op == FSAG_FL_ERASE_PAGE)
    else $error("no page erase");
  a_full_erase: assert property (
    jtag_ready && jtag_req.valid && jtag_req.op == FSAG_JTAG_ERASE
    && jtag_req.addr[15:1] == 15'h0eff |=> flash_cmd.valid
    && flash_cmd.op == FSAG_FL_ERASE_ALL) else $error("no full erase");
  a_limit_read: assert property (
    reg_rd && reg_addr == FSAG_OFS_ACCESS_LIMIT |=> reg_rdata == lim_q)
    else $error("limit readback wrong");
endmodule
bind fsag_guard fsag_guard_assertions i_fsag_guard_assertions (.core_clk,
  .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req,
  .cpu_ready, .cpu_rsp, .jtag_req, .jtag_ready, .flash_cmd);
`default_nettype wire

/* File: test/fsag_flash_model.sv */
// Behavioural flash array answering the guard
`timescale 1ns/1ps
`default_nettype none
module fsag_flash_model import fsag_pkg::*; (
  // Guard side and read delay
  input  wire logic               core_clk,
  input  wire fsag_flash_cmd_type flash_cmd,
  input  wire logic [2:0]         delay,
  output var  logic               flash_busy,
  output var  logic               flash_rvalid,
  output var  logic [7:0]         flash_rdata
);
  logic [7:0]  mem [0:16'h207f]; // Contents
  logic [15:0] a_q;              // Read address
  logic [2:0]  n_q = 3'h0;       // Answer countdown
  logic [7:0]  t_q = 8'h00;      // Busy time, idle pattern
  // Image with lock bytes preset
  initial begin
    for (int i = 0; i < 16'h2080; i++) mem[i] = 8'(i ^ (i >> 8));
    mem[FSAG_ADDR_READ_LOCK] = 8'hfe;
    mem[FSAG_ADDR_WRITE_LOCK] = 8'hfd;
  end
  // Read after delay, write clears bits, erase sets
  always @(posedge core_clk) begin
    t_q <= t_q + 8'h01;
    n_q <= (n_q != 3'h0) ? n_q - 3'h1 : 3'h0;
    if (flash_cmd.valid && flash_cmd.op == FSAG_FL_READ) begin
      a_q <= flash_cmd.addr;
      n_q <= delay;
    end else if (flash_cmd.valid) begin
      t_q <= 8'h00;
      for (int i = 0; i < 16'h2080; i++)
        if (flash_cmd.op == FSAG_FL_WRITE ? i == flash_cmd.addr :
            flash_cmd.op == FSAG_FL_ERASE_ALL ? i < 16'h2000 :
            flash_cmd.addr[13] ? i >= 16'h2000 : i[15:9] == flash_cmd.addr[15:9])
          mem[i] <= (flash_cmd.op == FSAG_FL_WRITE) ?
                    mem[i] & flash_cmd.wdata : 8'hff;
    end
  end
  assign flash_busy = (t_q < 8'h02);
  assign flash_rvalid = (n_q == 3'h1);
  assign flash_rdata = flash_rvalid ? mem[a_q] : t_q;
endmodule
`default_nettype wire

/* File: test/fsag_guard_test.sv */
// Self-checking bench of the flash security access guard
`timescale 1ns/1ps
`default_nettype none
module fsag_guard_test import fsag_pkg::*;;
  logic               core_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic [2:0]         reg_addr = 3'h0;
  logic [7:0]         reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  logic [2:0]         delay = 3'h1;
  fsag_cpu_req_type   cpu_req = '0;
  fsag_jtag_req_type  jtag_req = '0;
  fsag_rsp_type       cpu_rsp, jtag_rsp;
  fsag_flash_cmd_type flash_cmd;
  logic               cpu_ready, jtag_ready, flash_busy, flash_rvalid;
  logic [7:0]         reg_rdata, flash_rdata;
  int                 fail_count = 0, n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  fsag_guard i_fsag_guard (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cpu_req, .cpu_ready, .cpu_rsp, .jtag_req,
    .jtag_ready, .jtag_rsp, .flash_cmd, .flash_busy, .flash_rvalid,
    .flash_rdata);
  fsag_flash_model i_fsag_flash_model (.core_clk, .flash_cmd, .delay,
    .flash_busy, .flash_rvalid, .flash_rdata);
  function automatic logic [7:0] pat(logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  task automatic chk(string w, logic [7:0] e, logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rg(bit w, logic [2:0] a, logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask
  // Held request until answer; j picks the debug port
  task automatic req(bit j, logic [1:0] op, logic [15:0] pc, logic [15:0] a,
                     logic [7:0] d, logic er, logic [7:0] ed);
    fsag_rsp_type r;
    int n;
    @(posedge core_clk);
    if (j) jtag_req <= '{1'b1, fsag_jtag_op_type'(op), a, d};
    else cpu_req <= '{1'b1, fsag_cpu_op_type'(op), pc, a, d};
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
      r = j ? jtag_rsp : cpu_rsp;
    end while (r.valid !== 1'b1 && n < 100);
    if (r.valid !== 1'b1) begin
      fail_count++;
      finish_test();
    end
    @(posedge core_clk);
    cpu_req.valid <= 1'b0;
    jtag_req.valid <= 1'b0;
    chk("refused", {7'h0, er}, {7'h0, r.refused});
    if (j ? op == 2'h0 : op != 2'h2) chk("rdata", ed, r.rdata);
  endtask
  initial begin
    logic [7:0]  v;
    logic [15:0] p, a;
    v = 8'($urandom(32'h1806));
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rg(0, 3'h0, 8'h00, v);
    chk("control", FSAG_RST_STORE_CONTROL, v);
    rg(0, 3'h7, 8'h00, v);
    chk("unmapped", 8'h00, v);
    req(0, 1, 16'h1800, 16'h0100, 0, 0, pat(16'h0100));
    rg(0, 3'h2, 8'h00, v);
    chk("read lock", 8'hfe, v);
    rg(0, 3'h3, 8'h00, v);
    chk("write lock", 8'hfd, v);
    rg(1, 3'h1, 8'h10, v);
    for (int i = 0; i < 24; i++) begin
      p = (i < 2) ? 16'h0fff + 16'(i) : 16'($urandom_range(16'h1bff));
      a = (i < 2) ? 16'h0fff : 16'($urandom_range(16'h1bff));
      delay <= 3'($urandom_range(4, 1));
      v = (p >= 16'h1000 && a < 16'h1000) ? 8'h01 : 8'h00;
      req(0, 1, p, a, 0, v[0], v[0] ? 8'h00 : pat(a));
    end
    req(0, 0, 16'h1800, 16'h0100, 0, 0, pat(16'h0100));
    req(0, 2, 16'h0200, 16'h2005, 8'h0f, 1, 0);
    rg(1, 3'h0, 8'h01, v);
    req(0, 2, 16'h1800, 16'h0100, 0, 1, 0);
    req(0, 2, 16'h0200, 16'h2005, 8'h0f, 0, 0);
    req(0, 1, 16'h0200, 16'h2005, 0, 0, 8'h05);
    rg(1, 3'h0, 8'h03, v);
    req(0, 2, 16'h0200, 16'h1c10, 0, 1, 0);
    req(0, 2, 16'h0200, 16'h2005, 0, 0, 0);
    req(0, 1, 16'h0200, 16'h2005, 0, 0, 8'hff);
    req(1, 0, 0, 16'h0100, 0, 1, 0);
    req(1, 0, 0, 16'h0400, 0, 0, pat(16'h0400));
    req(1, 1, 0, 16'h0500, 0, 1, 0);
    req(1, 2, 0, 16'h0600, 0, 1, 0);
    rg(0, 3'h4, 8'h00, v);
    chk("status", 8'h03, v);
    rg(1, 3'h4, 8'h03, v);
    rg(0, 3'h4, 8'h00, v);
    chk("status", 8'h00, v);
    req(1, 1, 0, 16'h1dff, 8'h7f, 0, 0);
    req(1, 1, 0, 16'h1dff, 8'hff, 0, 0);
    req(1, 0, 0, 16'h1c00, 0, 1, 0);
    req(1, 0, 0, 16'h1dff, 0, 0, 8'h7e);
    req(1, 2, 0, 16'h1c10, 0, 0, 0);
    rg(0, 3'h2, 8'h00, v);
    chk("read lock", 8'hff, v);
    req(1, 2, 0, 16'h1dfe, 0, 0, 0);
    req(1, 0, 0, 16'h0100, 0, 0, 8'hff);
    finish_test();
  end
endmodule
`default_nettype wire
